/* hw/iocd_ddr_in.sv */
// Double-rate capture half of the I/O cell: two edge registers and a latch.
// Assumes the pin is launched source-synchronously with the cell clock.
`timescale 1ns/100ps
module iocd_ddr_in #(
  parameter logic INIT_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic srst_i,
  input wire logic pad_i,
  output logic rise_o,
  output logic fall_o
);
  logic rise_q;
  logic fall_q;
  logic fall_lat;

  // RL10 - rising edge capture
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_q <= INIT_VAL;
    end else if (srst_i) begin
      rise_q <= INIT_VAL;
    end else begin
      rise_q <= pad_i;
    end
  end

  // RL10 - falling edge capture
  always_ff @(negedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_q <= INIT_VAL;
    end else if (srst_i) begin
      fall_q <= INIT_VAL;
    end else begin
      fall_q <= pad_i;
    end
  end

  // RL11 - hold high-phase bit
  // The latch closes while the clock is high so the fall bit cannot move
  // under the rising edge that consumes it together with the rise bit.
  always_latch begin
    if (!arst_n_i) begin
      fall_lat = INIT_VAL;
    end else if (!clk_i) begin
      fall_lat = fall_q;
    end
  end

  assign rise_o = rise_q;
  assign fall_o = fall_lat;

  chk_rise_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && !$past(srst_i) |-> rise_q == $past(pad_i)) // RL10
    else $error("rise register missed the pin");

  chk_latch_steady: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fall_lat == fall_q) // RL11
    else $error("latch does not present the fall bit at the rise");
endmodule

/* hw/iocd_ddr_out.sv */
// Double-rate launch half of the I/O cell: data and enable registers.
// Assumes the fabric holds its data stable for a whole clock period.
`timescale 1ns/100ps
module iocd_ddr_out #(
  parameter logic INIT_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic srst_i,
  input wire logic hi_i,
  input wire logic lo_i,
  input wire logic oe_i,
  output logic pad_o,
  output logic pad_oe_o
);
  logic hi_q;
  logic lo_q;
  logic oe_q;
  logic oe_n_q;

  // RL12 - first output register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_q <= INIT_VAL;
      oe_q <= 1'b0;
    end else if (srst_i) begin
      hi_q <= INIT_VAL;
      oe_q <= 1'b0;
    end else begin
      hi_q <= hi_i;
      oe_q <= oe_i;
    end
  end

  // RL12 - second output register
  always_ff @(negedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_q <= INIT_VAL;
      oe_n_q <= 1'b0;
    end else if (srst_i) begin
      lo_q <= INIT_VAL;
      oe_n_q <= 1'b0;
    end else begin
      lo_q <= lo_i;
      oe_n_q <= oe_q;
    end
  end

  // RL12 - phase selected drive
  // The high register loads at the rising edge that selects it and the low
  // register at the falling edge, so each bit stands a full half period.
  assign pad_o = clk_i ? hi_q : lo_q;
  // RL13 - release on disable
  assign pad_oe_o = oe_q & oe_n_q;

  chk_hi_launch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && !$past(srst_i) |-> hi_q == $past(hi_i)) // RL12
    else $error("high phase register did not take the fabric bit");

  chk_oe_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !$past(oe_i) |-> !pad_oe_o) // RL13
    else $error("pin still driven after enable fell");
endmodule

/* hw/iocd_pkg.sv */
// Types shared by the I/O cell register stage.
// Assumes the register header is on the include path.
package iocd_pkg;
  `include "iocd_regs.svh"

  typedef enum logic [1:0] {
    IOCD_MODE_IN = 2'h0,
    IOCD_MODE_OUT = 2'h1,
    IOCD_MODE_BIDIR = 2'h2,
    IOCD_MODE_RSVD = 2'h3
  } iocd_mode_t;

  typedef enum logic [2:0] {
    IOCD_ST_IDLE = 3'h1,
    IOCD_ST_ACC = 3'h2,
    IOCD_ST_DONE = 3'h4
  } iocd_apb_st_t;
endpackage

/* hw/iocd_regs.svh */
// Register map, field positions, reset values and timing of the I/O cell.
// Assumes it is included by bare name from the package and the bench.
`ifndef IOCD_REGS_SVH
`define IOCD_REGS_SVH

`define IOCD_OFS_CTRL 12'h000
`define IOCD_OFS_TXD 12'h004
`define IOCD_OFS_STAT 12'h008

`define IOCD_CTRL_MODE_LSB 0
`define IOCD_CTRL_MODE_MSB 1
`define IOCD_CTRL_SRST_BIT 2

`define IOCD_TXD_HI_BIT 0
`define IOCD_TXD_LO_BIT 1
`define IOCD_TXD_OE_BIT 2

`define IOCD_STAT_HI_BIT 0
`define IOCD_STAT_LO_BIT 1
`define IOCD_STAT_OE_BIT 2
`define IOCD_STAT_INIT_BIT 3

`define IOCD_CTRL_RST 3'h0
`define IOCD_TXD_RST 3'h0

`define IOCD_CLK_PERIOD_NS 4
`define IOCD_ACCESS_CYC 1

`endif

/* hw/iocd_top.sv */
// Top of the I/O cell register stage with an APB register file.
// Assumes one fabric clock on both edges, and that the async control and
// the sync reset come from logic on that clock.
//
// Summary of operation
// RL1 - One shared clear/preset net for all registers.
// RL2 - Preset or clear chosen once per cell.
// RL3 - Registers start at the chosen level; the enable registers oe_q and oe_n_q start at zero.
// RL4 - Low start: async control clears to zero.
// RL5 - High start: async control presets to one; the enable registers still clear to zero.
// RL6 - Every register needing async control shares it.
// RL7 - Synchronous reset acts on the clock edge.
// RL8 - Six registers give double-rate capture and launch.
// RL9 - Modes: input, output, bidirectional double rate.
// RL10 - Two capture registers on opposite edges.
// RL11 - Latch aligns both bits to one edge.
// RL12 - Pin driven hi-phase first, lo-phase second.
// RL13 - Enable low releases pin, capture continues.
`timescale 1ns/100ps
module iocd_top #(
  parameter logic INIT_HIGH = 1'b0
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic ACLR_N_I,
  input wire logic SRST_I,
  input wire logic [11:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PAD_I,
  output logic PAD_O,
  output logic PAD_OE_O,
  output logic RX_HI_O,
  output logic RX_LO_O
);
  import iocd_pkg::*;

  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_TXD = 3'h2;
  localparam logic [2:0] IDX_STAT = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h0;

  logic cell_arst_n;
  logic cell_srst;
  iocd_apb_st_t st_q;
  iocd_apb_st_t st_d;
  iocd_mode_t mode_q;
  logic soft_srst_q;
  logic tx_hi_q;
  logic tx_lo_q;
  logic tx_oe_q;
  logic drv_hi;
  logic drv_lo;
  logic drv_oe;
  logic cap_rise;
  logic cap_fall;
  logic rx_hi_q;
  logic rx_lo_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] idx;
  logic wr_hit;
  logic rd_hit;

  // Byte address to one-hot register select; empty for unmapped words.
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    logic [2:0] sel;
    sel = IDX_NONE;
    unique case (addr)
      `IOCD_OFS_CTRL: sel = IDX_CTRL;
      `IOCD_OFS_TXD: sel = IDX_TXD;
      `IOCD_OFS_STAT: sel = IDX_STAT;
      default: sel = IDX_NONE;
    endcase
    return sel;
  endfunction

  // Reserved mode code falls back to input so the pin is never driven.
  function automatic logic mode_drives(input iocd_mode_t m, input logic oe);
    logic d;
    d = 1'b0;
    unique case (m)
      IOCD_MODE_OUT: d = 1'b1;
      IOCD_MODE_BIDIR: d = oe;
      default: d = 1'b0;
    endcase
    return d;
  endfunction

  // RL1 - one shared async net
  // RL6 - same net for all
  // Gating the fabric control with the chip reset keeps one net for all six
  // cell registers; a per-register control would allow mixed states.
  assign cell_arst_n = NRST_I & ACLR_N_I;
  // RL7 - sync reset source
  assign cell_srst = SRST_I | soft_srst_q;

  assign idx = reg_sel(PADDR_I);

  // APB access: setup, two wait cycles, answer cycle.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      IOCD_ST_IDLE: begin
        if (PSEL_I && PENABLE_I) begin
          st_d = IOCD_ST_ACC;
        end
      end
      IOCD_ST_ACC: begin
        st_d = IOCD_ST_DONE;
      end
      IOCD_ST_DONE: begin
        st_d = IOCD_ST_IDLE;
      end
      default: begin
        st_d = IOCD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q <= IOCD_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // The write lands on the edge that also raises pready, so it takes effect
  // one edge before the edge where the master samples pready high.
  assign wr_hit = (st_q == IOCD_ST_ACC) && PWRITE_I && PSTRB_I[0];
  assign rd_hit = (st_q == IOCD_ST_ACC) && !PWRITE_I;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= (st_q == IOCD_ST_ACC);
      pslverr_q <= (st_q == IOCD_ST_ACC) && (idx == IDX_NONE);
    end
  end

  // RL9 - mode select register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_q <= IOCD_MODE_IN;
      soft_srst_q <= 1'b0;
    end else if (wr_hit && idx == IDX_CTRL) begin
      mode_q <= iocd_mode_t'(
        PWDATA_I[`IOCD_CTRL_MODE_MSB:`IOCD_CTRL_MODE_LSB]);
      soft_srst_q <= PWDATA_I[`IOCD_CTRL_SRST_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_hi_q <= 1'b0;
      tx_lo_q <= 1'b0;
      tx_oe_q <= 1'b0;
    end else if (wr_hit && idx == IDX_TXD) begin
      tx_hi_q <= PWDATA_I[`IOCD_TXD_HI_BIT];
      tx_lo_q <= PWDATA_I[`IOCD_TXD_LO_BIT];
      tx_oe_q <= PWDATA_I[`IOCD_TXD_OE_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_hit) begin
      prdata_q <= 32'h0000_0000;
      unique case (idx)
        IDX_CTRL: begin
          prdata_q[`IOCD_CTRL_MODE_MSB:`IOCD_CTRL_MODE_LSB] <= mode_q;
          prdata_q[`IOCD_CTRL_SRST_BIT] <= soft_srst_q;
        end
        IDX_TXD: begin
          prdata_q[`IOCD_TXD_HI_BIT] <= tx_hi_q;
          prdata_q[`IOCD_TXD_LO_BIT] <= tx_lo_q;
          prdata_q[`IOCD_TXD_OE_BIT] <= tx_oe_q;
        end
        IDX_STAT: begin
          prdata_q[`IOCD_STAT_HI_BIT] <= rx_hi_q;
          prdata_q[`IOCD_STAT_LO_BIT] <= rx_lo_q;
          prdata_q[`IOCD_STAT_OE_BIT] <= drv_oe;
          prdata_q[`IOCD_STAT_INIT_BIT] <= INIT_HIGH;
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // RL9 - mode steers drive
  // RL13 - bidir enable from fabric
  assign drv_hi = tx_hi_q;
  assign drv_lo = tx_lo_q;
  assign drv_oe = mode_drives(mode_q, tx_oe_q);

  // RL2 - per-cell fixed level
  // RL3 - start level
  // RL4 - clear when low
  // RL5 - preset when high
  // RL8 - two capture registers
  iocd_ddr_in #(
    .INIT_VAL(INIT_HIGH)
  ) u_in (
    .clk_i(CLK_I),
    .arst_n_i(cell_arst_n),
    .srst_i(cell_srst),
    .pad_i(PAD_I),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // RL8 - four launch registers
  iocd_ddr_out #(
    .INIT_VAL(INIT_HIGH)
  ) u_out (
    .clk_i(CLK_I),
    .arst_n_i(cell_arst_n),
    .srst_i(cell_srst),
    .hi_i(drv_hi),
    .lo_i(drv_lo),
    .oe_i(drv_oe),
    .pad_o(PAD_O),
    .pad_oe_o(PAD_OE_O)
  );

  // RL11 - aligned pair to fabric
  // RL13 - capture runs in every mode
  // The pair holds the high-phase bit with the low-phase bit that came just
  // before it on the wire; re-pairing would cost a seventh register.
  always_ff @(posedge CLK_I or negedge cell_arst_n) begin
    if (!cell_arst_n) begin
      rx_hi_q <= INIT_HIGH;
      rx_lo_q <= INIT_HIGH;
    end else if (cell_srst) begin
      rx_hi_q <= INIT_HIGH;
      rx_lo_q <= INIT_HIGH;
    end else begin
      rx_hi_q <= cap_fall;
      rx_lo_q <= cap_rise;
    end
  end

  assign RX_HI_O = rx_hi_q;
  assign RX_LO_O = rx_lo_q;
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

  chk_sync_reset: assert property (@(posedge CLK_I) disable iff (!cell_arst_n)
    SRST_I |=> rx_hi_q == INIT_HIGH && rx_lo_q == INIT_HIGH) // RL7
    else $error("sync reset did not load the start level");

  chk_async_level: assert property (@(posedge CLK_I)
    !cell_arst_n |-> rx_hi_q == INIT_HIGH && rx_lo_q == INIT_HIGH) // RL4
    else $error("async control did not force the start level");

  chk_pair_align: assert property (@(posedge CLK_I) disable iff (!cell_arst_n)
    $past(cell_arst_n) && !$past(cell_srst) |-> rx_lo_q == $past(cap_rise)
      && rx_hi_q == $past(cap_fall)) // RL11
    else $error("captured pair not aligned to one edge");

  chk_input_mode: assert property (@(posedge CLK_I) disable iff (!cell_arst_n)
    mode_q == IOCD_MODE_IN [*2] |-> !PAD_OE_O) // RL9
    else $error("pin driven in input mode");

  chk_output_mode: assert property (@(posedge CLK_I) disable iff (!cell_arst_n)
    (mode_q == IOCD_MODE_OUT && !cell_srst) [*3] |-> PAD_OE_O) // RL9
    else $error("pin not driven in output mode");

  chk_apb_answer: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (PSEL_I && PENABLE_I && st_q == IOCD_ST_IDLE) |=> ##1 PREADY_O)
    else $error("apb answer not two cycles after access");

  chk_apb_unmapped: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    PREADY_O && $past(idx == IDX_NONE) |-> PSLVERR_O)
    else $error("unmapped address answered without error");
endmodule

/* verif/iocd_pad_model.sv */
// Far-side device on the pin: drives random double-rate bits on request.
// Assumes the bench tells it when the cell has released the pin.
`timescale 1ns/100ps
module iocd_pad_model (
  input wire logic clk_i,
  input wire logic drv_en_i,
  input wire logic pad_o_i,
  input wire logic pad_oe_i,
  output logic pin_o
);
  integer seed = 96;
  logic [31:0] rnd;
  logic drv_q = 1'b0;
  logic flt_q = 1'b0;
  wire loop_w;
  // A new bit on each edge; the cell samples the previous bit at that edge.
  always @(clk_i) begin
    rnd = $random(seed);
    drv_q <= rnd[0];
    flt_q <= ~flt_q;
  end
  // A short wire delay keeps the looped-back pin from racing the capture
  // edge, since the cell's pin mux switches on the clock itself.
  assign #0.5 loop_w = pad_o_i;
  // A released pin left undriven by the model toggles, so a stale value can never pass for real data.
  assign pin_o = pad_oe_i ? loop_w : (drv_en_i ? drv_q : flt_q);
endmodule

/* verif/iocd_top_tb.sv */
// Self-checking bench for the I/O cell register stage.
// Assumes the pad model sits on the pin and APB is the only register path.
`timescale 1ns/100ps
`include "iocd_regs.svh"
module iocd_top_tb;
  import iocd_pkg::*;
  localparam logic INIT = 1'b1;
  typedef struct packed {
    logic [31:0] d;
    logic rd;
    logic err;
  } iocd_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic aclr_n = 1'b1;
  logic srst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, pad_o, pad_oe, rx_hi, rx_lo, pad_w;
  logic drv_en = 1'b0;
  logic rx_en = 1'b0;
  logic hw, ho, lo_s, lo_prev;
  logic [1:0] rxe;
  iocd_exp_t ae;
  iocd_exp_t apb_q[$];
  logic [1:0] rx_q[$];
  integer err_count = 0;
  integer comparisons = 0;
  integer seed = 96;
  integer cyc = 0;
  logic [31:0] rnd;

  iocd_top #(.INIT_HIGH(INIT)) iocd_top_i (
    .CLK_I(clk), .NRST_I(rst_n), .ACLR_N_I(aclr_n), .SRST_I(srst),
    .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PAD_I(pad_w), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
    .RX_HI_O(rx_hi), .RX_LO_O(rx_lo)
  );

  iocd_pad_model iocd_pad_model_i (
    .clk_i(clk), .drv_en_i(drv_en), .pad_o_i(pad_o), .pad_oe_i(pad_oe),
    .pin_o(pad_w)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd, input logic [3:0] st,
                     input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    pstrb <= st;
    apb_q.push_back({exp, ~w, err});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Mid-phase samples keep clear of the edge where the pin mux switches.
  always @(posedge clk) begin
    #1;
    hw = pad_w;
    ho = pad_o;
  end
  always @(negedge clk) begin
    #1;
    lo_s = pad_o;
    // Each pair is a high-phase bit and the low-phase bit just before it.
    rx_q.push_back({hw, lo_prev});
    lo_prev = pad_w;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  always @(posedge clk) begin
    if (rx_en !== 1'b1) begin
      rx_q.delete();
    end else if (rx_q.size() >= 2) begin
      rxe = rx_q.pop_front();
      cmp({30'h0, rx_hi, rx_lo}, {30'h0, rxe}, "rx pair");
    end
  end

  always @(posedge clk) begin
    if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
      if (apb_q.size() == 0) begin
        cmp(32'h1, 32'h0, "unexpected pready");
      end else begin
        ae = apb_q.pop_front();
        cmp({31'h0, pslverr}, {31'h0, ae.err}, "pslverr");
        if (ae.rd) begin
          cmp(prdata, ae.d, "prdata");
        end
      end
    end
  end

  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmp({29'h0, pad_oe, rx_hi, rx_lo}, {29'h0, 1'b0, INIT, INIT}, "rst");
    cmp({31'h0, pad_o}, {31'h0, INIT}, "rst pad");
    rst_n <= 1'b1;
    @(posedge clk);
    apb(`IOCD_OFS_CTRL, 1'b0, 32'h0, 4'hF, {29'h0, `IOCD_CTRL_RST}, 1'b0);
    apb(`IOCD_OFS_TXD, 1'b0, 32'h0, 4'hF, {29'h0, `IOCD_TXD_RST}, 1'b0);
    apb(12'h00C, 1'b1, 32'h7, 4'hF, 32'h0, 1'b1);
    apb(`IOCD_OFS_TXD, 1'b1, 32'h7, 4'h0, 32'h0, 1'b0);
    apb(`IOCD_OFS_TXD, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0);
    drv_en <= 1'b1;
    rx_en <= 1'b1;
    repeat (40) @(posedge clk);
    rx_en <= 1'b0;
    drv_en <= 1'b0;
    apb(`IOCD_OFS_CTRL, 1'b1, 32'h1, 4'hF, 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rnd = $random(seed);
      apb(`IOCD_OFS_TXD, 1'b1, rnd, 4'hF, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      cmp({29'h0, pad_oe, ho, lo_s}, {29'h0, 1'b1, rnd[0], rnd[1]}, "pad");
      apb(`IOCD_OFS_TXD, 1'b0, 32'h0, 4'hF, {29'h0, rnd[2:0]}, 1'b0);
    end
    apb(`IOCD_OFS_TXD, 1'b1, {30'h0, ~INIT, ~INIT}, 4'hF, 32'h0, 1'b0);
    repeat (4) @(posedge clk);
    cmp({30'h0, rx_hi, rx_lo}, {30'h0, ~INIT, ~INIT}, "loopback");
    aclr_n <= 1'b0;
    #1;
    cmp({28'h0, pad_oe, pad_o, rx_hi, rx_lo}, {28'h0, 1'b0, {3{INIT}}},
        "async clear");
    @(posedge clk);
    apb(`IOCD_OFS_STAT, 1'b0, 32'h0, 4'hF, {28'h0, INIT, 1'b1, INIT, INIT},
        1'b0);
    apb(`IOCD_OFS_CTRL, 1'b0, 32'h0, 4'hF, 32'h1, 1'b0);
    aclr_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({30'h0, pad_oe, ho}, {30'h0, 1'b1, ~INIT}, "clear release");
    srst <= 1'b1;
    #1;
    cmp({31'h0, pad_oe}, 32'h1, "sync only");
    repeat (3) @(posedge clk);
    cmp({29'h0, pad_oe, ho, lo_s}, {29'h0, 1'b0, INIT, INIT}, "srst");
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp({29'h0, pad_oe, ho, lo_s}, {29'h0, 1'b1, ~INIT, ~INIT}, "srst off");
    apb(`IOCD_OFS_CTRL, 1'b1, 32'h5, 4'hF, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    cmp({30'h0, pad_oe, ho}, {30'h0, 1'b0, INIT}, "soft srst");
    apb(`IOCD_OFS_TXD, 1'b1, 32'h7, 4'hF, 32'h0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      apb(`IOCD_OFS_CTRL, 1'b1, m, 4'hF, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      cmp({31'h0, pad_oe}, {31'h0, m == 1 || m == 2}, "mode oe");
      apb(`IOCD_OFS_CTRL, 1'b0, 32'h0, 4'hF, m, 1'b0);
    end
    apb(`IOCD_OFS_TXD, 1'b1, 32'h3, 4'hF, 32'h0, 1'b0);
    apb(`IOCD_OFS_CTRL, 1'b1, 32'h2, 4'hF, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    cmp({31'h0, pad_oe}, 32'h0, "bidir release");
    drv_en <= 1'b1;
    rx_en <= 1'b1;
    repeat (30) @(posedge clk);
    rx_en <= 1'b0;
    @(posedge clk);
    summarize();
  end
endmodule
